/* File: cnsf_map.svh */
// Function
// [R1] Receive flags clear only by writing one
// [R2] Clear ignored while setting condition persists
// [R3] Hard and soft reset clear receive flags
// [R4] Bus activity in sleep sets wakeup flag
// [R5] Receive warning: counter 96..127, no passive/off
// [R6] Transmit warning: counter 96..127, no passive/off
// [R7] Receive passive: counter 128..255, not bus-off
// [R8] Transmit passive: counter 128..255, not bus-off
// [R9] Bus-off above 255; clear after 128 idles
// [R10] Overrun sets flag; enabled gives error interrupt
// [R11] Full flag blocks background to foreground move
// [R12] CPU clears full flag after reading message
// [R13] CPU reads receive buffer only when full
// [R14] Enables route flags to their interrupt lines
// [R15] Soft reset holds receive enables reset
// [R16] Acknowledge read-only, empty write-one-clear, reset
// [R17] Empty set on send or granted abort
// [R18] CPU loads buffer, then clears empty flag
// [R19] Clearing empty also clears abort acknowledge
// [R20] Abort request CPU-set, cleared when empty sets
// [R21] Grant abort if unstarted or failed; flag both
// [R22] Never clear empty and request abort together
// [R23] Per-buffer enable gates transmit empty interrupt
// [R24] Soft reset aborts traffic, keeps error counters
// [R25] Interrupt lines are OR of enabled flags
`ifndef CNSF_MAP_SVH
`define CNSF_MAP_SVH
// Register byte addresses.
`define CNSF_A_CTL0 8'h00
`define CNSF_A_RFLG 8'h04
`define CNSF_A_RIER 8'h08
`define CNSF_A_TFLG 8'h0C
`define CNSF_A_TCTL 8'h10
`define CNSF_A_ECNT 8'h14
// Field positions.
`define CNSF_C0_SOFT  0
`define CNSF_C0_SLEEP 1
`define CNSF_RF_RXF  0
`define CNSF_RF_OVR  1
`define CNSF_RF_BOFF 2
`define CNSF_RF_TPAS 3
`define CNSF_RF_RPAS 4
`define CNSF_RF_TWRN 5
`define CNSF_RF_RWRN 6
`define CNSF_RF_WUP  7
`define CNSF_TF_TXE 0
`define CNSF_TF_ABK 4
`define CNSF_TC_IE  0
`define CNSF_TC_ABQ 4
`define CNSF_EC_TEC 8
// Reset values.
`define CNSF_RST_RFLG 8'h00
`define CNSF_RST_RIER 8'h00
`define CNSF_RST_TXE  3'h7
`define CNSF_RST_SOFT 1'h1
// Error counter thresholds.
`define CNSF_WARN_LO 8'h60
`define CNSF_WARN_HI 8'h7F
`define CNSF_PASS_LO 8'h80
`define CNSF_BOFF_LIM 9'h0FF
`define CNSF_RECOV_N 8'h80
`endif

/* File: cnsf_pkg.sv */
package cnsf_pkg;
    // Status and events from the protocol engine, same clock.
    typedef struct packed {
        logic       sleep_mode;
        logic       bus_activity;
        logic [7:0] receive_error_counter;
        logic [8:0] transmit_error_counter;
        logic       recessive_seq;
        logic       overrun;
        logic       rx_msg_ok;
        logic [2:0] tx_sent;
        logic [2:0] tx_active;
        logic [2:0] tx_failed;
    } cnsf_eng_t;
    // Interrupt request lines.
    typedef struct packed {
        logic wakeup;
        logic error;
        logic receive;
        logic transmit;
    } cnsf_irq_t;
    typedef enum logic {CNSF_IDLE, CNSF_ANS} cnsf_bus_st_t;
endpackage

/* File: cnsf_status.sv */
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "cnsf_map.svh"
module cnsf_status
    import cnsf_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    input  wire cnsf_eng_t   eng,
    output cnsf_irq_t        irq,
    output logic             soft_reset_out,
    output logic             fg_load,
    output logic [2:0]       tx_request,
    output logic [2:0]       abort_grant
);
    cnsf_bus_st_t st_q;
    cnsf_bus_st_t st_d;
    logic         soft_q;
    logic [7:0]   rflg_q;
    logic [7:0]   rier_q;
    logic [2:0]   txe_q;
    logic [2:0]   abtak_q;
    logic [2:0]   abtrq_q;
    logic [2:0]   txeie_q;
    logic [7:0]   recov_q;
    logic [31:0]  rdata_q;
    cnsf_irq_t    irq_q;
    logic [7:0]   wd;
    logic         wr_ok;
    logic         wr_ctl;
    logic         wr_rflg;
    logic         wr_rier;
    logic         wr_tflg;
    logic         wr_tctl;
    logic         hrst;
    logic [7:0]   rset;
    logic [7:0]   rhold;
    logic         rwarn_c;
    logic         twarn_c;
    logic         rpass_c;
    logic         tpass_c;
    logic         boff_c;
    logic         boff_hold;
    logic [2:0]   txe_set;
    logic [2:0]   txe_clr;
    logic [31:0]  rd_mux;

    // Bus handshake: every access sees exactly one wait cycle.
    always_comb begin
        st_d = st_q;
        case (st_q)
            CNSF_IDLE: if (read || write) st_d = CNSF_ANS;
            CNSF_ANS:  st_d = CNSF_IDLE;
            default:   st_d = CNSF_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= CNSF_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign waitrequest = (read || write) && (st_q != CNSF_ANS);
    assign readdata    = rdata_q;

    // Writes take effect on the edge where waitrequest is low.
    assign wd      = writedata[7:0];
    assign wr_ok   = (st_q == CNSF_ANS) && write && byteenable[0];
    assign wr_ctl  = wr_ok && (address == `CNSF_A_CTL0);
    assign wr_rflg = wr_ok && (address == `CNSF_A_RFLG);
    assign wr_rier = wr_ok && (address == `CNSF_A_RIER);
    assign wr_tflg = wr_ok && (address == `CNSF_A_TFLG);
    assign wr_tctl = wr_ok && (address == `CNSF_A_TCTL);

    // Held reset: hard reset or soft reset bit set.
    assign hrst = !rst_n || soft_q;

    // Soft reset bit; it tells the engine to abort and resync.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            soft_q <= `CNSF_RST_SOFT;
        end else if (wr_ctl) begin
            soft_q <= wd[`CNSF_C0_SOFT];
        end
    end

    assign soft_reset_out = soft_q; // R24

    // Error state conditions from the engine counters.
    always_comb begin
        rwarn_c = (eng.receive_error_counter >= `CNSF_WARN_LO) && (eng.receive_error_counter <= `CNSF_WARN_HI) // R5
                  && !rflg_q[`CNSF_RF_RPAS] && !rflg_q[`CNSF_RF_TPAS] && !rflg_q[`CNSF_RF_BOFF];
        twarn_c = (eng.transmit_error_counter >= {1'b0, `CNSF_WARN_LO}) && (eng.transmit_error_counter <= {1'b0, `CNSF_WARN_HI}) // R6
                  && !rflg_q[`CNSF_RF_RPAS] && !rflg_q[`CNSF_RF_TPAS] && !rflg_q[`CNSF_RF_BOFF];
        rpass_c = (eng.receive_error_counter >= `CNSF_PASS_LO) && !rflg_q[`CNSF_RF_BOFF]; // R7
        tpass_c = (eng.transmit_error_counter >= {1'b0, `CNSF_PASS_LO}) && (eng.transmit_error_counter <= `CNSF_BOFF_LIM) // R8
                  && !rflg_q[`CNSF_RF_BOFF];
        boff_c  = eng.transmit_error_counter > `CNSF_BOFF_LIM; // R9
    end

    // Bus-off recovery: count idle sequences while the flag stands.
    always_ff @(posedge clk) begin
        if (hrst || !rflg_q[`CNSF_RF_BOFF]) begin
            recov_q <= 8'h00;
        end else if (eng.recessive_seq && (recov_q != `CNSF_RECOV_N)) begin
            recov_q <= recov_q + 8'h01; // R9
        end
    end

    assign boff_hold = boff_c || (recov_q != `CNSF_RECOV_N); // R9

    // Set events and clear-blocking conditions per receive flag.
    always_comb begin
        rset = 8'h00;
        rset[`CNSF_RF_WUP]  = eng.sleep_mode && eng.bus_activity; // R4
        rset[`CNSF_RF_RWRN] = rwarn_c;
        rset[`CNSF_RF_TWRN] = twarn_c;
        rset[`CNSF_RF_RPAS] = rpass_c;
        rset[`CNSF_RF_TPAS] = tpass_c;
        rset[`CNSF_RF_BOFF] = boff_c;
        rset[`CNSF_RF_OVR]  = eng.overrun; // R10
        rset[`CNSF_RF_RXF]  = fg_load; // R11
        rhold = rset; // R2
        rhold[`CNSF_RF_BOFF] = boff_hold; // R2
    end

    // Receive flags: set wins, one clears unless condition persists.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_rflg
            always_ff @(posedge clk) begin
                if (hrst) begin
                    rflg_q[gi] <= 1'(`CNSF_RST_RFLG >> gi); // R3
                end else if (rset[gi]) begin
                    rflg_q[gi] <= 1'b1;
                end else if (wr_rflg && wd[gi] && !rhold[gi]) begin
                    rflg_q[gi] <= 1'b0; // R1
                end
            end
        end
    endgenerate

    // Foreground reload only while the full flag is clear.
    assign fg_load = eng.rx_msg_ok && !rflg_q[`CNSF_RF_RXF]; // R11

    // Receive interrupt enables, held reset during soft reset.
    always_ff @(posedge clk) begin
        if (hrst) begin
            rier_q <= `CNSF_RST_RIER; // R15
        end else if (wr_rier) begin
            rier_q <= wd;
        end
    end

    // Transmit buffers: empty, acknowledge, request and enable.
    generate
        for (gi = 0; gi < 3; gi++) begin : g_tx
            assign abort_grant[gi] = abtrq_q[gi] && !txe_q[gi] && !hrst // R21
                                     && (!eng.tx_active[gi] || eng.tx_failed[gi]);
            assign txe_set[gi] = eng.tx_sent[gi] || abort_grant[gi]; // R17
            assign txe_clr[gi] = wr_tflg && wd[`CNSF_TF_TXE + gi] && !txe_set[gi];

            always_ff @(posedge clk) begin
                if (hrst) begin
                    txe_q[gi] <= 1'(`CNSF_RST_TXE >> gi); // R16
                end else if (txe_set[gi]) begin
                    txe_q[gi] <= 1'b1; // R17
                end else if (txe_clr[gi]) begin
                    txe_q[gi] <= 1'b0; // R16
                end
            end

            always_ff @(posedge clk) begin
                if (hrst) begin
                    abtak_q[gi] <= 1'b0; // R16
                end else if (abort_grant[gi]) begin
                    abtak_q[gi] <= 1'b1; // R21
                end else if (txe_clr[gi]) begin
                    abtak_q[gi] <= 1'b0; // R19
                end
            end

            always_ff @(posedge clk) begin
                if (hrst) begin
                    abtrq_q[gi] <= 1'b0;
                end else if (txe_set[gi]) begin
                    abtrq_q[gi] <= 1'b0; // R20
                end else if (wr_tctl && wd[`CNSF_TC_ABQ + gi] && !txe_q[gi]) begin
                    abtrq_q[gi] <= 1'b1; // R20
                end
            end

            always_ff @(posedge clk) begin
                if (hrst) begin
                    txeie_q[gi] <= 1'b0;
                end else if (wr_tctl) begin
                    txeie_q[gi] <= wd[`CNSF_TC_IE + gi];
                end
            end
        end
    endgenerate

    // Scheduled buffers are those whose empty flag is clear.
    assign tx_request = ~txe_q;

    // Interrupt lines, registered so they leave from flops.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_q <= '0;
        end else begin
            irq_q.wakeup   <= rflg_q[`CNSF_RF_WUP] && rier_q[`CNSF_RF_WUP]; // R14
            irq_q.error    <= |(rflg_q[`CNSF_RF_RWRN:`CNSF_RF_OVR] & rier_q[`CNSF_RF_RWRN:`CNSF_RF_OVR]); // R25
            irq_q.receive  <= rflg_q[`CNSF_RF_RXF] && rier_q[`CNSF_RF_RXF]; // R14
            irq_q.transmit <= |(txe_q & txeie_q); // R23
        end
    end

    assign irq = irq_q;

    // Read mux; unmapped addresses read as zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (address)
            `CNSF_A_CTL0: begin
                rd_mux[`CNSF_C0_SOFT]  = soft_q;
                rd_mux[`CNSF_C0_SLEEP] = eng.sleep_mode;
            end
            `CNSF_A_RFLG: rd_mux[7:0] = rflg_q;
            `CNSF_A_RIER: rd_mux[7:0] = rier_q;
            `CNSF_A_TFLG: begin
                rd_mux[`CNSF_TF_TXE +: 3] = txe_q;
                rd_mux[`CNSF_TF_ABK +: 3] = abtak_q;
            end
            `CNSF_A_TCTL: begin
                rd_mux[`CNSF_TC_IE +: 3]  = txeie_q;
                rd_mux[`CNSF_TC_ABQ +: 3] = abtrq_q;
            end
            `CNSF_A_ECNT: begin
                rd_mux[7:0]               = eng.receive_error_counter;
                rd_mux[`CNSF_EC_TEC +: 9] = eng.transmit_error_counter;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the wait cycle and stands at the answer.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if ((st_q == CNSF_IDLE) && read) begin
            rdata_q <= rd_mux;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_w1c_zero; // R1
        (wr_rflg && (wd == 8'h00) && !soft_q) |=> ((rflg_q & $past(rflg_q)) == $past(rflg_q));
    endproperty
    a_w1c_zero: assert property (p_w1c_zero) else $error("Receive flag dropped on zero write."); // R1

    property p_boff_refused; // R2
        (wr_rflg && wd[`CNSF_RF_BOFF] && rflg_q[`CNSF_RF_BOFF] && boff_hold && !soft_q) |=> rflg_q[`CNSF_RF_BOFF];
    endproperty
    a_boff_refused: assert property (p_boff_refused) else $error("Bus-off flag cleared too early."); // R2

    property p_soft_rflg; // R3
        soft_q |=> (rflg_q == `CNSF_RST_RFLG);
    endproperty
    a_soft_rflg: assert property (p_soft_rflg) else $error("Receive flags not held in soft reset."); // R3

    property p_soft_rier; // R15
        soft_q[*2] |-> (rier_q == `CNSF_RST_RIER);
    endproperty
    a_soft_rier: assert property (p_soft_rier) else $error("Enables not held in soft reset."); // R15

    property p_wakeup; // R4
        (!soft_q && eng.sleep_mode && eng.bus_activity) |=> rflg_q[`CNSF_RF_WUP];
    endproperty
    a_wakeup: assert property (p_wakeup) else $error("Wakeup flag not set."); // R4

    property p_rwarn; // R5
        (!soft_q && rwarn_c) |=> rflg_q[`CNSF_RF_RWRN];
    endproperty
    a_rwarn: assert property (p_rwarn) else $error("Receive warning flag not set."); // R5

    property p_boff_set; // R9
        (!soft_q && (eng.transmit_error_counter > `CNSF_BOFF_LIM)) |=> rflg_q[`CNSF_RF_BOFF] ##1 rflg_q[`CNSF_RF_BOFF] || soft_q;
    endproperty
    a_boff_set: assert property (p_boff_set) else $error("Bus-off flag not set."); // R9

    property p_fg_block; // R11
        rflg_q[`CNSF_RF_RXF] |-> !fg_load;
    endproperty
    a_fg_block: assert property (p_fg_block) else $error("Foreground reloaded while full."); // R11

    property p_abtak_clr; // R19
        (!$past(soft_q) && $fell(txe_q[0])) |-> !abtak_q[0];
    endproperty
    a_abtak_clr: assert property (p_abtak_clr) else $error("Acknowledge kept after empty cleared."); // R19

    property p_abtrq_clr; // R20
        $rose(txe_q[1]) |-> !abtrq_q[1];
    endproperty
    a_abtrq_clr: assert property (p_abtrq_clr) else $error("Abort request kept after empty set."); // R20

    property p_grant; // R21
        (abort_grant[2] && !soft_q) |=> (txe_q[2] && abtak_q[2]) || soft_q;
    endproperty
    a_grant: assert property (p_grant) else $error("Granted abort not flagged."); // R21

    property p_err_irq; // R25
        (|(rflg_q[`CNSF_RF_RWRN:`CNSF_RF_OVR] & rier_q[`CNSF_RF_RWRN:`CNSF_RF_OVR])) |=> irq.error;
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("Error interrupt missing."); // R25

    property p_tx_irq; // R23
        (|(txe_q & txeie_q)) |=> irq.transmit;
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("Transmit interrupt missing."); // R23

    // The remaining band flags and overrun, then interrupt lines and transmit flags, so that a broken set path in any band is caught.
    property p_twarn; // R6
        (!soft_q && twarn_c) |=> rflg_q[`CNSF_RF_TWRN];
    endproperty
    a_twarn: assert property (p_twarn) else $error("Transmit warning flag not set."); // R6

    property p_rpass; // R7
        (!soft_q && rpass_c) |=> rflg_q[`CNSF_RF_RPAS];
    endproperty
    a_rpass: assert property (p_rpass) else $error("Receive passive flag not set."); // R7

    property p_tpass; // R8
        (!soft_q && tpass_c) |=> rflg_q[`CNSF_RF_TPAS];
    endproperty
    a_tpass: assert property (p_tpass) else $error("Transmit passive flag not set."); // R8

    property p_ovr; // R10
        (!soft_q && eng.overrun) |=> rflg_q[`CNSF_RF_OVR];
    endproperty
    a_ovr: assert property (p_ovr) else $error("Overrun flag not set."); // R10

    property p_rx_irq; // R14
        (rflg_q[`CNSF_RF_RXF] && rier_q[`CNSF_RF_RXF]) |=> irq.receive;
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("Receive interrupt missing."); // R14

    property p_wup_irq; // R14
        (rflg_q[`CNSF_RF_WUP] && rier_q[`CNSF_RF_WUP]) |=> irq.wakeup;
    endproperty
    a_wup_irq: assert property (p_wup_irq) else $error("Wakeup interrupt missing."); // R14

    property p_sent; // R17
        (!soft_q && eng.tx_sent[1]) |=> txe_q[1];
    endproperty
    a_sent: assert property (p_sent) else $error("Empty flag not set after send."); // R17

    property p_soft_tflg; // R16
        soft_q |=> (txe_q == `CNSF_RST_TXE) && (abtak_q == 3'h0);
    endproperty
    a_soft_tflg: assert property (p_soft_tflg) else $error("Transmit flags not held in soft reset."); // R16

    // Only a set empty flag or a reset may take a pending request away; a TCTL write cannot.
    property p_abtrq_keep; // R20
        (abtrq_q[0] && !txe_set[0] && !soft_q) |=> abtrq_q[0];
    endproperty
    a_abtrq_keep: assert property (p_abtrq_keep) else $error("Abort request lost without empty set."); // R20
endmodule

/* File: cnsf_eng_model.sv */
`timescale 1ns/10ps
module cnsf_eng_model
    import cnsf_pkg::*;
(
    input  wire logic clk,
    output cnsf_eng_t eng
);
    // The engine starts idle with both error counters at zero.
    initial eng = '0;
    // Counters change only between frames, so one update per call is enough.
    task automatic ctr(input logic [7:0] r, input logic [8:0] t);
        @(posedge clk);
        eng.receive_error_counter <= r;
        eng.transmit_error_counter <= t;
    endtask
    // Levels: sleep, bus activity and the buffers now on the wire.
    task automatic lvl(input logic s, input logic a, input logic [2:0] act);
        @(posedge clk);
        eng.sleep_mode   <= s;
        eng.bus_activity <= a;
        eng.tx_active    <= act;
    endtask
    // One-cycle events: 0 overrun, 1 message, 2 idle sequence, 3 sent, 4 failed.
    task automatic pulse(input int sel, input logic [2:0] b);
        @(posedge clk);
        eng.overrun       <= (sel == 0);
        eng.rx_msg_ok     <= (sel == 1);
        eng.recessive_seq <= (sel == 2);
        eng.tx_sent       <= (sel == 3) ? b : 3'h0;
        eng.tx_failed     <= (sel == 4) ? b : 3'h0;
        @(posedge clk);
        {eng.overrun, eng.rx_msg_ok, eng.recessive_seq} <= 3'h0;
        {eng.tx_sent, eng.tx_failed} <= 6'h00;
    endtask
endmodule

/* File: test_can_status_flags_and_tx_abort.sv */
`timescale 1ns/10ps
`include "cnsf_map.svh"
module test_can_status_flags_and_tx_abort
    import cnsf_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  address = 8'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0]  byteenable = 4'h1;
    logic [31:0] readdata;
    logic        waitrequest;
    cnsf_eng_t   eng;
    cnsf_irq_t   irq;
    logic        soft_reset_out;
    logic        fg_load;
    logic [2:0]  tx_request;
    logic [2:0]  abort_grant;
    int          mismatches = 0;
    int          num_checks = 0;
    int          fg_cnt = 0;
    int          ag_cnt = 0;
    int          seed = 44074;
    logic [31:0] rd_q;
    logic [31:0] rv;
    logic [24:0] tbl [10];
    // Register image of the bench model, indexed by address over four.
    logic [7:0]  mdl [8] = '{8'h01, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00};

    always #4 clk = ~clk;
    // Background moves are counted so that a blocked move shows up later.
    always @(posedge clk) if (fg_load === 1'b1) fg_cnt <= fg_cnt + 1;
    // Granted aborts are counted, so a grant given while a buffer is on the wire shows up.
    always @(posedge clk) if (abort_grant !== 3'h0) ag_cnt <= ag_cnt + 1;

    cnsf_status dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .eng(eng), .irq(irq), .soft_reset_out(soft_reset_out), .fg_load(fg_load),
        .tx_request(tx_request), .abort_grant(abort_grant));
    cnsf_eng_model eng_m (.clk(clk), .eng(eng));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
        num_checks++;
        if (seen !== expv) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, expv, seen);
        end
    endtask
    // One bus cycle; the request is held until waitrequest is seen low.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge clk);
        address <= a;
        read <= !wr;
        write <= wr;
        byteenable <= be;
        writedata <= {24'($random(seed)), d};
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        rd_q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask
    // Every read is compared with the image, and the interrupt lines with it too.
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 8'h00, 4'h1);
        check($sformatf("reg %h", a), rd_q, {24'h0, mdl[a[4:2]]});
        check("irq", 32'(irq), {28'h0, mdl[1][7] & mdl[2][7], |(mdl[1][6:1] & mdl[2][6:1]),
            mdl[1][0] & mdl[2][0], |(mdl[3][2:0] & mdl[4][2:0])});
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard, far beyond the well under one thousand cycles the sequence needs.
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        end_of_test();
    end

    initial begin
        rv = $random(seed);
        tbl = '{{8'h64, 9'h000, 8'h40}, {8'h7F, 9'h000, 8'h40}, {8'h80, 9'h000, 8'h10},
            {8'hFF, 9'h000, 8'h10}, {8'h00, 9'h060, 8'h20}, {8'h00, 9'h07F, 8'h20},
            {8'h00, 9'h080, 8'h08}, {8'h00, 9'h0FF, 8'h08}, {8'h64, 9'h064, 8'h60},
            {1'b0, rv[6:0] % 7'h60, 9'h05F, 8'h00}};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a <= 24; a += 4) if (a != 20) rd(8'(a));
        wr(`CNSF_A_RIER, 8'hFF);
        rd(`CNSF_A_RIER);
        bus(1'b1, `CNSF_A_CTL0, 8'h00, 4'hE);
        check("soft", 32'(soft_reset_out), 32'h1);
        wr(`CNSF_A_CTL0, 8'h00);
        wr(`CNSF_A_RIER, 8'hFF);
        mdl[0] = 8'h00;
        mdl[2] = 8'hFF;
        rd(`CNSF_A_RIER);
        // Error counter bands: set, refused clear, write of zero, real clear.
        foreach (tbl[i]) begin
            eng_m.ctr(tbl[i][24:17], tbl[i][16:8]);
            repeat (2) @(posedge clk);
            mdl[1] = tbl[i][7:0];
            rd(`CNSF_A_RFLG);
            wr(`CNSF_A_RFLG, 8'hFF);
            rd(`CNSF_A_RFLG);
            eng_m.ctr(8'h00, 9'h000);
            wr(`CNSF_A_RFLG, 8'h00);
            rd(`CNSF_A_RFLG);
            wr(`CNSF_A_RFLG, 8'hFF);
            mdl[1] = 8'h00;
            rd(`CNSF_A_RFLG);
        end
        // Bus-off stays until the 128th idle sequence has gone by.
        eng_m.ctr(8'h00, 9'h100);
        repeat (2) @(posedge clk);
        mdl[1] = 8'h04;
        rd(`CNSF_A_RFLG);
        eng_m.ctr(8'h00, 9'h000);
        repeat (127) eng_m.pulse(2, 3'h0);
        wr(`CNSF_A_RFLG, 8'hFF);
        rd(`CNSF_A_RFLG);
        eng_m.pulse(2, 3'h0);
        wr(`CNSF_A_RFLG, 8'hFF);
        mdl[1] = 8'h00;
        rd(`CNSF_A_RFLG);
        eng_m.pulse(0, 3'h0);
        mdl[1] = 8'h02;
        rd(`CNSF_A_RFLG);
        eng_m.lvl(1'b1, 1'b1, 3'h0);
        eng_m.lvl(1'b1, 1'b0, 3'h0);
        mdl[1] = 8'h82;
        rd(`CNSF_A_RFLG);
        wr(`CNSF_A_RFLG, 8'h82);
        eng_m.lvl(1'b0, 1'b0, 3'h0);
        // A second message must not displace the one still held.
        eng_m.pulse(1, 3'h0);
        eng_m.pulse(1, 3'h0);
        mdl[1] = 8'h01;
        rd(`CNSF_A_RFLG);
        check("moves", 32'(fg_cnt), 32'h1);
        wr(`CNSF_A_RFLG, 8'h01);
        mdl[1] = 8'h00;
        rd(`CNSF_A_RFLG);
        wr(`CNSF_A_TCTL, 8'h07);
        mdl[4] = 8'h07;
        rd(`CNSF_A_TCTL);
        // Per buffer: schedule, refused abort while sending, failure grants it, then a send.
        for (int b = 0; b < 3; b++) begin
            wr(`CNSF_A_TFLG, 8'(1 << b));
            mdl[3] &= ~8'(1 << b);
            rd(`CNSF_A_TFLG);
            check("request", 32'(tx_request), {29'h0, ~mdl[3][2:0]});
            eng_m.lvl(1'b0, 1'b0, 3'(1 << b));
            wr(`CNSF_A_TCTL, 8'h07 | 8'(8'h10 << b));
            mdl[4] |= 8'(8'h10 << b);
            wr(`CNSF_A_TCTL, 8'h07);
            rd(`CNSF_A_TCTL);
            eng_m.pulse(4, 3'(1 << b));
            mdl[3] |= 8'(8'h11 << b);
            mdl[4] = 8'h07;
            rd(`CNSF_A_TCTL);
            eng_m.lvl(1'b0, 1'b0, 3'h0);
            wr(`CNSF_A_TFLG, 8'h70);
            rd(`CNSF_A_TFLG);
            wr(`CNSF_A_TFLG, 8'(1 << b));
            mdl[3] &= ~8'(8'h11 << b);
            rd(`CNSF_A_TFLG);
            eng_m.pulse(3, 3'(1 << b));
            mdl[3] |= 8'(1 << b);
            rd(`CNSF_A_TFLG);
        end
        wr(`CNSF_A_TFLG, 8'h04);
        wr(`CNSF_A_TCTL, 8'h47);
        mdl[3] = 8'h47;
        rd(`CNSF_A_TFLG);
        check("grants", 32'(ag_cnt), 32'h4);
        // Soft reset mid-run resets everything but the error counters.
        eng_m.ctr(8'h12, 9'h034);
        eng_m.pulse(0, 3'h0);
        wr(`CNSF_A_CTL0, 8'h01);
        mdl = '{8'h01, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int a = 0; a <= 16; a += 4) rd(8'(a));
        bus(1'b0, `CNSF_A_ECNT, 8'h00, 4'h1);
        check("counters", rd_q, {15'h0, 9'h034, 8'h12});
        end_of_test();
    end
endmodule
